// *** amr_defines.svh ***
`ifndef AMR_DEFINES_SVH
`define AMR_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define AMR_OFS_MON1_CTRL 8'h00
`define AMR_OFS_RESULT0 8'h04
`define AMR_OFS_RESULT1 8'h08
`define AMR_OFS_SOFT_RST 8'h0c
`define AMR_OFS_IRQ_STATUS 8'h10
`define AMR_OFS_IRQ_MASK 8'h14

// ****************************************
// field positions
// ****************************************
`define AMR_CTRL_EN_BIT 0
`define AMR_CTRL_SEL_LSB 1
`define AMR_CTRL_SEL_MSB 4
`define AMR_CTRL_DIR_BIT 5
`define AMR_RES_VAL_LSB 6
`define AMR_RES_VAL_MSB 15
`define AMR_RES_OVR_BIT 1
`define AMR_RES_RF_BIT 0
`define AMR_SRST_LSB 0
`define AMR_SRST_MSB 1
`define AMR_IRQ_MON1_BIT 0
`define AMR_IRQ_RESULT0_OVERRUN_BIT 1
`define AMR_IRQ_RESULT1_OVERRUN_BIT 2

// ****************************************
// values
// ****************************************
`define AMR_RESET_WORD 32'h0000_0000
`define AMR_SRST_ARM 2'h2
`define AMR_SRST_FIRE 2'h1
`define AMR_RESULT_W 10
`define AMR_IRQ_W 3
// index that the sequencer gives the top-priority result
`define AMR_TOP_PRIO_IDX 4'h8

`endif

// *** amr_pkg.sv ***
package amr_pkg;

  // one store of a conversion result, from the sequencer
  typedef struct packed {
    logic valid;
    logic [3:0] index;
    logic [9:0] data;
  } amr_result_evt_t;

  typedef struct packed {
    logic dir;
    logic [3:0] sel;
    logic en;
  } amr_ctrl_t;

  typedef enum {
    AMR_REG_CTRL,
    AMR_REG_RES0,
    AMR_REG_RES1,
    AMR_REG_SRST,
    AMR_REG_STAT,
    AMR_REG_MASK,
    AMR_REG_NONE
  } amr_reg_t;

  typedef enum {
    AMR_SR_IDLE,
    AMR_SR_ARMED
  } amr_srst_t;

endpackage

// *** amr_result_reg.sv ***
`timescale 1ns/1ns
`include "amr_defines.svh"
module amr_result_reg #(
  parameter int W = `AMR_RESULT_W
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic store_in,
  input wire logic [W-1:0] data_in,
  input wire logic read_in,
  input wire logic seen_ovr_in,
  output logic [W-1:0] value_out,
  output logic ovr_out,
  output logic stored_out
);
  logic [W-1:0] value_q, value_d;
  logic ovr_q, ovr_d;
  logic rf_q, rf_d;

  always_comb begin
    value_d = value_q;
    ovr_d = ovr_q;
    rf_d = rf_q;
    // only an overrun flag that software actually saw is cleared; the result flag clears on any read
    if (read_in && seen_ovr_in) begin
      ovr_d = 1'b0;
    end
    if (read_in) begin
      rf_d = 1'b0;
    end
    // a store in the clearing cycle wins
    if (store_in) begin
      value_d = data_in;
      rf_d = 1'b1;
      if (rf_q && !read_in) begin
        ovr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      value_q <= '0;
      ovr_q <= 1'b0;
      rf_q <= 1'b0;
    end else begin
      value_q <= value_d;
      ovr_q <= ovr_d;
      rf_q <= rf_d;
    end
  end

  assign value_out = value_q;
  assign ovr_out = ovr_q;
  assign stored_out = rf_q;
endmodule

// *** amr_top.sv ***
`timescale 1ns/1ns
`include "amr_defines.svh"
module amr_top #(
  parameter int RW = `AMR_RESULT_W,
  parameter int NRES = 2
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire amr_pkg::amr_result_evt_t result_evt_in,
  input wire logic [RW-1:0] cmp1_value_in,
  output amr_pkg::amr_ctrl_t monitor1_control_out,
  output logic monitor1_match_out,
  output logic soft_reset_out,
  output logic irq_out
);
  import amr_pkg::*;

  // ****************************************
  // address decode
  // ****************************************
  function automatic amr_reg_t decode_addr(input logic [7:0] a);
    amr_reg_t r;
    r = AMR_REG_NONE;
    if (a == `AMR_OFS_MON1_CTRL) begin
      r = AMR_REG_CTRL;
    end else if (a == `AMR_OFS_RESULT0) begin
      r = AMR_REG_RES0;
    end else if (a == `AMR_OFS_RESULT1) begin
      r = AMR_REG_RES1;
    end else if (a == `AMR_OFS_SOFT_RST) begin
      r = AMR_REG_SRST;
    end else if (a == `AMR_OFS_IRQ_STATUS) begin
      r = AMR_REG_STAT;
    end else if (a == `AMR_OFS_IRQ_MASK) begin
      r = AMR_REG_MASK;
    end
    return r;
  endfunction

  // ****************************************
  // helpers
  // ****************************************
  // a write lands only at completion and only with the low byte lane on
  function automatic logic lane0_hit(input logic wd, input logic be0, input amr_reg_t at,
    input amr_reg_t want);
    return wd && be0 && (at == want);
  endfunction

  // every result register shares one word layout
  function automatic logic [31:0] result_word(input logic [RW-1:0] v, input logic o, input logic f);
    logic [31:0] w;
    w = `AMR_RESET_WORD;
    w[`AMR_RES_VAL_MSB:`AMR_RES_VAL_LSB] = v;
    w[`AMR_RES_OVR_BIT] = o;
    w[`AMR_RES_RF_BIT] = f;
    return w;
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  amr_reg_t cur_reg;
  logic take, done, wr_done, rd_done;
  logic clr;
  amr_ctrl_t ctrl_q, ctrl_d;
  amr_srst_t sr_q, sr_d;
  logic srst_q, srst_d;
  logic hit_q, hit_d;
  logic [3:0] sel_idx;
  logic sel_store;
  logic below, above;
  logic [`AMR_IRQ_W-1:0] stat_q, stat_d;
  logic [`AMR_IRQ_W-1:0] mask_q, mask_d;
  logic [`AMR_IRQ_W-1:0] ev;
  logic irq_q, irq_d;
  logic [NRES-1:0] res_store;
  logic [NRES-1:0] res_read;
  logic [NRES-1:0] res_ovr;
  logic [NRES-1:0] res_rf;
  logic [NRES-1:0] res_ovr_ev;
  logic [RW-1:0] res_val [NRES];

  assign cur_reg = decode_addr(avs_address_in);
  // register state, bus state excluded, follows soft reset too
  assign clr = rst_in | srst_q;

  // ****************************************
  // bus slave
  // ****************************************
  // first cycle of a request captures read data, second completes it;
  // write effects and read side effects happen only at completion
  assign take = (avs_read_in | avs_write_in) & wait_q;
  assign done = (avs_read_in | avs_write_in) & ~wait_q;
  assign wr_done = done & avs_write_in;
  assign rd_done = done & avs_read_in;

  always_comb begin
    wait_d = 1'b1;
    rdata_d = rdata_q;
    if (take) begin
      wait_d = 1'b0;
      rdata_d = `AMR_RESET_WORD;
      if (avs_read_in) begin
        if (cur_reg == AMR_REG_CTRL) begin
          rdata_d[`AMR_CTRL_DIR_BIT] = ctrl_q.dir;
          rdata_d[`AMR_CTRL_SEL_MSB:`AMR_CTRL_SEL_LSB] = ctrl_q.sel;
          rdata_d[`AMR_CTRL_EN_BIT] = ctrl_q.en;
        end else if (cur_reg == AMR_REG_RES0) begin
          rdata_d = result_word(res_val[0], res_ovr[0], res_rf[0]);
        end else if (cur_reg == AMR_REG_RES1) begin
          rdata_d = result_word(res_val[1], res_ovr[1], res_rf[1]);
        end else if (cur_reg == AMR_REG_STAT) begin
          rdata_d[`AMR_IRQ_W-1:0] = stat_q;
        end else if (cur_reg == AMR_REG_MASK) begin
          rdata_d[`AMR_IRQ_W-1:0] = mask_q;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wait_q <= 1'b1;
      rdata_q <= `AMR_RESET_WORD;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // monitor 1 control
  // ****************************************
  always_comb begin
    ctrl_d = ctrl_q;
    if (lane0_hit(wr_done, avs_byteenable_in[0], cur_reg, AMR_REG_CTRL)) begin
      ctrl_d.dir = avs_writedata_in[`AMR_CTRL_DIR_BIT];
      ctrl_d.sel = avs_writedata_in[`AMR_CTRL_SEL_MSB:`AMR_CTRL_SEL_LSB];
      ctrl_d.en = avs_writedata_in[`AMR_CTRL_EN_BIT];
    end
  end

  always_ff @(posedge clk_in) begin
    if (clr) begin
      ctrl_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ****************************************
  // soft reset sequence
  // ****************************************
  // any other value written to this register, except a repeated 10, breaks the sequence, so a stray 01 never resets
  always_comb begin
    sr_d = sr_q;
    srst_d = 1'b0;
    if (lane0_hit(wr_done, avs_byteenable_in[0], cur_reg, AMR_REG_SRST)) begin
      case (sr_q)
        AMR_SR_IDLE: begin
          if (avs_writedata_in[`AMR_SRST_MSB:`AMR_SRST_LSB] == `AMR_SRST_ARM) begin
            sr_d = AMR_SR_ARMED;
          end
        end
        AMR_SR_ARMED: begin
          if (avs_writedata_in[`AMR_SRST_MSB:`AMR_SRST_LSB] == `AMR_SRST_FIRE) begin
            srst_d = 1'b1;
            sr_d = AMR_SR_IDLE;
          end else if (avs_writedata_in[`AMR_SRST_MSB:`AMR_SRST_LSB] != `AMR_SRST_ARM) begin
            sr_d = AMR_SR_IDLE;
          end
        end
        default: begin
          sr_d = AMR_SR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (clr) begin
      sr_q <= AMR_SR_IDLE;
    end else begin
      sr_q <= sr_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= srst_d;
    end
  end

  // ****************************************
  // result registers
  // ****************************************
  // only results 0 and 1 are held here; other indices only feed the monitor
  genvar gi;
  generate
    for (gi = 0; gi < NRES; gi++) begin : g_res
      assign res_store[gi] = result_evt_in.valid && (result_evt_in.index == 4'(gi));
      assign res_read[gi] = rd_done && (cur_reg == (gi == 0 ? AMR_REG_RES0 : AMR_REG_RES1));
      // overrun event mirrors the flag's own set condition
      assign res_ovr_ev[gi] = res_store[gi] & res_rf[gi] & ~res_read[gi];
      amr_result_reg #(
        .W(RW)
      ) u_res (
        .clk_in(clk_in),
        .rst_in(clr),
        .store_in(res_store[gi]),
        .data_in(result_evt_in.data),
        .read_in(res_read[gi]),
        .seen_ovr_in(rdata_q[`AMR_RES_OVR_BIT]),
        .value_out(res_val[gi]),
        .ovr_out(res_ovr[gi]),
        .stored_out(res_rf[gi])
      );
    end
  endgenerate

  // ****************************************
  // monitor 1 compare
  // ****************************************
  // codes 8..15 all map to the top-priority register
  assign sel_idx = ctrl_q.sel[3] ? `AMR_TOP_PRIO_IDX : {1'b0, ctrl_q.sel[2:0]};
  assign sel_store = result_evt_in.valid && (result_evt_in.index == sel_idx);
  // the incoming value is compared, so a hit costs no cycle after the store
  assign below = result_evt_in.data < cmp1_value_in;
  assign above = result_evt_in.data > cmp1_value_in;

  always_comb begin
    hit_d = 1'b0;
    if (ctrl_q.en && sel_store) begin
      hit_d = ctrl_q.dir ? above : below;
    end
  end

  always_ff @(posedge clk_in) begin
    if (clr) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= hit_d;
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  always_comb begin
    ev = '0;
    // a hit in flight when the enable drops raises no interrupt
    ev[`AMR_IRQ_MON1_BIT] = hit_q & ctrl_q.en;
    ev[`AMR_IRQ_RESULT0_OVERRUN_BIT] = res_ovr_ev[0];
    ev[`AMR_IRQ_RESULT1_OVERRUN_BIT] = res_ovr_ev[1];
  end

  always_comb begin
    stat_d = stat_q;
    mask_d = mask_q;
    if (lane0_hit(wr_done, avs_byteenable_in[0], cur_reg, AMR_REG_STAT)) begin
      stat_d = stat_q & ~avs_writedata_in[`AMR_IRQ_W-1:0];
    end
    if (lane0_hit(wr_done, avs_byteenable_in[0], cur_reg, AMR_REG_MASK)) begin
      mask_d = avs_writedata_in[`AMR_IRQ_W-1:0];
    end
    // new events beat a clear in the same cycle
    stat_d = stat_d | ev;
    // irq follows next-state status, so it rises with the status bit
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge clk_in) begin
    if (clr) begin
      stat_q <= '0;
      mask_q <= '0;
      irq_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign avs_readdata_out = rdata_q;
  assign avs_waitrequest_out = wait_q;
  assign monitor1_control_out = ctrl_q;
  assign monitor1_match_out = hit_q;
  assign soft_reset_out = srst_q;
  assign irq_out = irq_q;
endmodule

// *** amr_checker.sv ***
`timescale 1ns/1ns
module amr_checker #(
  parameter int RW = 10,
  parameter int NRES = 2
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire amr_pkg::amr_result_evt_t result_evt_in,
  input wire logic [RW-1:0] cmp1_value_in,
  input wire amr_pkg::amr_ctrl_t monitor1_control_out,
  input wire logic monitor1_match_out,
  input wire logic soft_reset_out,
  input wire logic irq_out
);
  import amr_pkg::*;
  // top bit of the selector means the top-priority register, index 8
  wire logic pick = monitor1_control_out.sel[3] ? result_evt_in.index == 4'h8
    : result_evt_in.index == monitor1_control_out.sel;
  wire logic lo = result_evt_in.data < cmp1_value_in;
  wire logic hi = result_evt_in.data > cmp1_value_in;
  wire logic rd_done = avs_read_in && !avs_waitrequest_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ****************
  // monitor 1
  // ****************
  sequence hit_s(d, c);
    result_evt_in.valid && pick && monitor1_control_out.en && monitor1_control_out.dir == d && c;
  endsequence
  below_hit_a: assert property (hit_s(1'b0, lo) |=> monitor1_match_out)
    else $error("low result missed");
  below_miss_a: assert property (hit_s(1'b0, !lo) |=> !monitor1_match_out)
    else $error("low compare false hit");
  above_hit_a: assert property (hit_s(1'b1, hi) |=> monitor1_match_out)
    else $error("high result missed");
  above_miss_a: assert property (hit_s(1'b1, !hi) |=> !monitor1_match_out)
    else $error("high compare false hit");
  other_reg_a: assert property (result_evt_in.valid && !pick |=> !monitor1_match_out)
    else $error("hit from unselected register");
  off_quiet_a: assert property (result_evt_in.valid && !monitor1_control_out.en |=> !monitor1_match_out)
    else $error("hit while disabled");
  idle_quiet_a: assert property (!result_evt_in.valid |=> !monitor1_match_out)
    else $error("hit without a stored result");
  // ****************
  // bus and reset
  // ****************
  bus_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("bus answer not one cycle");
  unmapped_zero_a: assert property (rd_done && (avs_address_in > 8'h14 || avs_address_in[1:0] != 2'h0
    || avs_address_in == 8'h0c) |-> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");
  srst_clear_a: assert property (soft_reset_out |=> !soft_reset_out ##[0:1] monitor1_control_out == '0)
    else $error("soft reset left control set");
endmodule
bind amr_top amr_checker #(.RW(RW), .NRES(NRES)) i_chk (
  .clk_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
  .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .result_evt_in,
  .cmp1_value_in, .monitor1_control_out, .monitor1_match_out, .soft_reset_out, .irq_out
);

// *** tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
  import amr_pkg::*;
  typedef struct packed {
    logic [5:0] ctrl;
    logic [3:0] idx;
    logic [9:0] data;
    logic [9:0] cmp;
    logic hit;
  } amr_row_t;
  logic clk_in = 0;
  logic rst_in = 1;
  logic [7:0] avs_address_in = 0;
  logic avs_read_in = 0;
  logic avs_write_in = 0;
  logic [31:0] avs_writedata_in = 0;
  logic [3:0] avs_byteenable_in = 4'hf;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  amr_result_evt_t result_evt_in = '0;
  logic [9:0] cmp1_value_in = 0;
  amr_ctrl_t monitor1_control_out;
  logic monitor1_match_out, soft_reset_out, irq_out, m;
  logic srst_seen = 0;
  logic [31:0] q, w;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  // ctrl is {dir, sel, en}
  amr_row_t rows [10] = '{'{6'h01, 4'h0, 10'h100, 10'h200, 1'b1}, '{6'h01, 4'h0, 10'h200, 10'h200, 1'b0},
    '{6'h01, 4'h0, 10'h201, 10'h200, 1'b0}, '{6'h21, 4'h0, 10'h201, 10'h200, 1'b1},
    '{6'h21, 4'h0, 10'h200, 10'h200, 1'b0}, '{6'h21, 4'h0, 10'h1ff, 10'h200, 1'b0},
    '{6'h00, 4'h0, 10'h100, 10'h200, 1'b0}, '{6'h03, 4'h0, 10'h100, 10'h200, 1'b0},
    '{6'h11, 4'h0, 10'h100, 10'h200, 1'b0}, '{6'h21, 4'h1, 10'h3ff, 10'h3fe, 1'b0}};
  always #2 clk_in = ~clk_in;
  amr_top i_dut (.clk_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .result_evt_in,
    .cmp1_value_in, .monitor1_control_out, .monitor1_match_out, .soft_reset_out, .irq_out);
  // ****************
  // tasks
  // ****************
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    @(posedge clk_in);
    while (avs_waitrequest_out !== 1'b0) @(posedge clk_in);
    q = avs_readdata_out;
    avs_write_in <= 0;
    avs_read_in <= 0;
    @(posedge clk_in);
  endtask
  // match is a one-cycle pulse, so it is caught in the cycle after the store
  task evt(input logic [3:0] i, input logic [9:0] dv);
    result_evt_in <= '{1'b1, i, dv};
    @(posedge clk_in);
    result_evt_in.valid <= 1'b0;
    @(posedge clk_in);
    m = monitor1_match_out;
  endtask
  task wrap_up;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (soft_reset_out === 1'b1) srst_seen <= 1;
    if (cyc == 5000) begin
      n_fail++;
      wrap_up;
    end
  end
  // ****************
  // tests
  // ****************
  initial begin
    repeat (8) @(posedge clk_in);
    rst_in <= 0;
    @(posedge clk_in);
    foreach (rows[i]) begin
      bus(1, 8'h00, {26'h0, rows[i].ctrl});
      cmp1_value_in <= rows[i].cmp;
      chk(monitor1_control_out, rows[i].ctrl);
      evt(rows[i].idx, rows[i].data);
      chk(m, rows[i].hit);
    end
    $display("test rows done");
    for (int s = 0; s < 16; s++) begin
      w = {26'h0, 1'b0, s[3:0], 1'b1};
      bus(1, 8'h00, w);
      bus(0, 8'h00, 0);
      chk(q, w);
      cmp1_value_in <= 10'h3ff;
      evt(s[3] ? 4'h8 : s[3:0], 10'h001);
      chk(m, 1);
    end
    $display("test selector done");
    rst_in <= 1;
    repeat (8) @(posedge clk_in);
    rst_in <= 0;
    @(posedge clk_in);
    for (int a = 0; a < 24; a += 4) begin
      bus(0, a[7:0], 0);
      chk(q, 0);
    end
    $display("test reset done");
    evt(4'h0, 10'h155);
    bus(0, 8'h04, 0);
    chk(q, {16'h0, 10'h155, 6'h01});
    bus(1, 8'h04, 32'hffff_ffff);
    bus(0, 8'h04, 0);
    chk(q, {16'h0, 10'h155, 6'h00});
    evt(4'h1, 10'h0aa);
    evt(4'h1, 10'h0ab);
    bus(0, 8'h08, 0);
    chk(q, {16'h0, 10'h0ab, 6'h03});
    bus(0, 8'h08, 0);
    chk(q, {16'h0, 10'h0ab, 6'h00});
    $display("test results done");
    bus(1, 8'h14, 32'h1);
    bus(1, 8'h00, 32'h1);
    cmp1_value_in <= 10'h200;
    evt(4'h0, 10'h100);
    @(posedge clk_in);
    chk(irq_out, 1);
    bus(1, 8'h10, 32'h1);
    @(posedge clk_in);
    chk(irq_out, 0);
    bus(0, 8'h10, 0);
    chk(q, 32'h4);
    bus(1, 8'h14, 32'h0);
    evt(4'h0, 10'h100);
    @(posedge clk_in);
    chk(irq_out, 0);
    bus(0, 8'h10, 0);
    chk(q, 32'h7);
    bus(1, 8'h20, 32'hffff);
    bus(0, 8'h20, 0);
    chk(q, 0);
    bus(0, 8'h02, 0);
    chk(q, 0);
    // a write without the low byte lane must leave control alone
    avs_byteenable_in <= 4'he;
    bus(1, 8'h00, 32'h0);
    avs_byteenable_in <= 4'hf;
    bus(0, 8'h00, 0);
    chk(q, 32'h1);
    $display("test irq and map done");
    // a stray value between the two steps must disarm the sequence
    bus(1, 8'h0c, 32'h2);
    bus(1, 8'h0c, 32'h3);
    bus(1, 8'h0c, 32'h1);
    bus(0, 8'h00, 0);
    chk(q, 32'h1);
    // arming twice stays armed
    bus(1, 8'h0c, 32'h2);
    bus(1, 8'h0c, 32'h2);
    bus(1, 8'h0c, 32'h1);
    repeat (3) @(posedge clk_in);
    chk(srst_seen, 1);
    for (int a = 0; a < 24; a += 4) begin
      bus(0, a[7:0], 0);
      chk(q, 0);
    end
    $display("test soft reset done");
    wrap_up;
  end
endmodule
